// ==== cpu_opcode_decode_tail.sv ====
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Function
// - Test sets N and Z from byte minus zero; H, I, C untouched.
// - Opcode 9F copies index to accumulator in 2 cycles, flags unchanged.
// - Opcode 8F clears I, halts CPU until interrupt, 2 cycles.
// - Word-offset indexed: offset high then low, added to index.
// - Extended: address high byte then low byte after opcode.
// - Bit branch: direct address byte, then relative offset byte.
// - Byte-offset indexed: one offset byte added unsigned to index.
// - Indexed no offset: no operand, index is the address.
// - Relative branch: signed offset added to next-instruction address.
// - Opcode 8E clears I, stops oscillator, enables interrupt pin.
module cpu_opcode_decode_tail (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic [3:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [7:0]  reg_rdata_out,
	output logic      [15:0] mem_addr_out,
	output logic             mem_rd_out,
	input  wire logic [7:0]  mem_rdata_in,
	input  wire logic        ext_irq_n_in,
	input  wire logic        int_req_in,
	output logic             halted_out,
	output logic             osc_stop_out,
	output logic             ext_irq_en_out
);

	typedef struct packed {
		cpu_tail_pkg::state_e st;
		logic [3:0]           cnt;
		logic [7:0]           opc;
		logic [7:0]           b1;
		logic [7:0]           rel;
		logic [7:0]           dat;
		logic [7:0]           acc;
		logic [7:0]           idx;
		logic [7:0]           rdata;
		logic [4:0]           flags;
		logic [15:0]          pc;
		logic [15:0]          ea;
		logic [15:0]          maddr;
		logic                 mrd;
		logic                 run;
		logic                 halted;
		logic                 stop;
		logic                 irq_en;
		logic                 illegal;
		logic                 sync1;
		logic                 sync2;
	} core_s;

	core_s       q;
	core_s       n;
	dec_if       dif ();
	logic        ready;
	logic        last;
	logic        load_ea;
	logic        fetch_data;
	logic        next_fetch;
	logic        bitv;
	logic [7:0]  dat;
	logic [7:0]  rel;
	logic [7:0]  val;
	logic [15:0] ea;
	logic [15:0] target;
	logic [15:0] prod;

	// Sign-extended branch target
	function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] off);
		return pc + {{8{off[7]}}, off};
	endfunction

	// Even opcode condition; odd opcode inverts it
	function automatic logic branch_cond(input logic [3:0] lsn, input logic [4:0] f,
			input logic pin);
		logic base;
		case (lsn[3:1])
			3'h0: base = 1'b1;
			3'h1: base = !(f[cpu_tail_pkg::FLAG_C] || f[cpu_tail_pkg::FLAG_Z]);
			3'h2: base = !f[cpu_tail_pkg::FLAG_C];
			3'h3: base = !f[cpu_tail_pkg::FLAG_Z];
			3'h4: base = !f[cpu_tail_pkg::FLAG_H];
			3'h5: base = !f[cpu_tail_pkg::FLAG_N];
			3'h6: base = !f[cpu_tail_pkg::FLAG_I];
			default: base = !pin;
		endcase
		return base ^ lsn[0];
	endfunction

	opcode_decoder u_dec (
		.dif (dif.dec)
	);

	// Decoder sees the byte on the bus while decoding, the latched opcode after
	assign dif.opcode = (q.st == cpu_tail_pkg::st_dec) ? mem_rdata_in : q.opc;
	assign fetch_data = (dif.op == cpu_tail_pkg::op_test_zero_neg) ||
		(dif.op == cpu_tail_pkg::op_branch_bit);
	assign last = (q.cnt == dif.cycles - 4'h1);

	always_comb begin
		n = q;
		ready = 1'b0;
		load_ea = 1'b0;
		next_fetch = 1'b1;
		bitv = 1'b0;
		dat = q.dat;
		rel = q.rel;
		ea = q.ea;
		target = q.pc;
		val = q.dat;
		prod = 16'h0000;
		n.sync1 = ext_irq_n_in;
		n.sync2 = q.sync1;
		n.rdata = 8'h00;
		n.mrd = 1'b0;
		n.cnt = q.cnt + 4'h1;
		// Register reads answer one cycle later, zero elsewhere
		if (reg_rd_in) begin
			case (reg_addr_in)
				cpu_tail_pkg::REG_CTRL: n.rdata[cpu_tail_pkg::CTRL_RUN] = q.run;
				cpu_tail_pkg::REG_STATUS: begin
					n.rdata[cpu_tail_pkg::STAT_HALT] = q.halted;
					n.rdata[cpu_tail_pkg::STAT_STOP] = q.stop;
					n.rdata[cpu_tail_pkg::STAT_ILLEGAL] = q.illegal;
					n.rdata[cpu_tail_pkg::STAT_IRQ_EN] = q.irq_en;
				end
				cpu_tail_pkg::REG_ACC: n.rdata = q.acc;
				cpu_tail_pkg::REG_INDEX: n.rdata = q.idx;
				cpu_tail_pkg::REG_FLAGS: n.rdata = {3'b000, q.flags};
				cpu_tail_pkg::REG_PC_LO: n.rdata = q.pc[7:0];
				cpu_tail_pkg::REG_PC_HI: n.rdata = q.pc[15:8];
				default: n.rdata = 8'h00;
			endcase
		end
		// Core state writable only while the core is parked
		if (reg_wr_in) begin
			if (reg_addr_in == cpu_tail_pkg::REG_CTRL)
				n.run = reg_wdata_in[cpu_tail_pkg::CTRL_RUN];
			if (reg_addr_in == cpu_tail_pkg::REG_STATUS && reg_wdata_in[cpu_tail_pkg::STAT_ILLEGAL])
				n.illegal = 1'b0;
			if (!q.run) begin
				case (reg_addr_in)
					cpu_tail_pkg::REG_ACC: n.acc = reg_wdata_in;
					cpu_tail_pkg::REG_INDEX: n.idx = reg_wdata_in;
					cpu_tail_pkg::REG_FLAGS: n.flags = reg_wdata_in[4:0];
					cpu_tail_pkg::REG_PC_LO: n.pc[7:0] = reg_wdata_in;
					cpu_tail_pkg::REG_PC_HI: n.pc[15:8] = reg_wdata_in;
					default: ;
				endcase
			end
		end
		// Sequencer: one memory byte per cycle, operand order fixed per mode
		if (q.run) begin
			case (q.st)
				cpu_tail_pkg::st_fetch: begin
					n.maddr = q.pc;
					n.mrd = 1'b1;
					n.pc = q.pc + 16'h0001;
					n.st = cpu_tail_pkg::st_dec;
					n.cnt = 4'h0;
				end
				cpu_tail_pkg::st_dec: begin
					n.opc = mem_rdata_in;
					if (dif.mode == cpu_tail_pkg::inherent_mode) begin
						ready = 1'b1;
					end else if (dif.mode == cpu_tail_pkg::indexed_no_offset) begin
						ea = {8'h00, q.idx};
						load_ea = 1'b1;
					end else begin
						n.maddr = q.pc;
						n.mrd = 1'b1;
						n.pc = q.pc + 16'h0001;
						n.st = cpu_tail_pkg::st_op1;
					end
				end
				cpu_tail_pkg::st_op1: begin
					n.b1 = mem_rdata_in;
					case (dif.mode)
						cpu_tail_pkg::direct_mode: begin
							ea = {8'h00, mem_rdata_in};
							load_ea = 1'b1;
						end
						cpu_tail_pkg::indexed_byte_offset: begin
							ea = {8'h00, q.idx} + {8'h00, mem_rdata_in};
							load_ea = 1'b1;
						end
						cpu_tail_pkg::relative_mode: begin
							rel = mem_rdata_in;
							ready = 1'b1;
						end
						default: begin
							n.maddr = q.pc;
							n.mrd = 1'b1;
							n.pc = q.pc + 16'h0001;
							n.st = cpu_tail_pkg::st_op2;
						end
					endcase
				end
				cpu_tail_pkg::st_op2: begin
					load_ea = 1'b1;
					case (dif.mode)
						cpu_tail_pkg::extended_mode: ea = {q.b1, mem_rdata_in};
						cpu_tail_pkg::indexed_word_offset:
							ea = {q.b1, mem_rdata_in} + {8'h00, q.idx};
						default: begin
							ea = {8'h00, q.b1};
							rel = mem_rdata_in;
						end
					endcase
				end
				cpu_tail_pkg::st_data: begin
					dat = mem_rdata_in;
					n.dat = mem_rdata_in;
					ready = 1'b1;
				end
				cpu_tail_pkg::st_exec: ready = 1'b1;
				cpu_tail_pkg::st_halt: begin
					// Stop wakes only from the pin, wait also from internal sources
					if (!q.sync2 || (!q.stop && int_req_in)) begin
						n.st = cpu_tail_pkg::st_fetch;
						n.halted = 1'b0;
						n.stop = 1'b0;
					end
				end
				default: n.st = cpu_tail_pkg::st_fetch;
			endcase
			if (load_ea) begin
				if (fetch_data) begin
					n.maddr = ea;
					n.mrd = 1'b1;
					n.st = cpu_tail_pkg::st_data;
				end else begin
					ready = 1'b1;
				end
			end
			n.ea = ea;
			n.rel = rel;
			// Pad to the documented count, then execute; all but wait and stop fetch the next opcode
			if (ready && !last) begin
				n.st = cpu_tail_pkg::st_exec;
			end else if (ready) begin
				case (dif.op)
					cpu_tail_pkg::op_test_zero_neg: begin
						if (dif.opcode == cpu_tail_pkg::OPC_TEST_ACC)
							val = q.acc;
						else if (dif.opcode == cpu_tail_pkg::OPC_TEST_INDEX)
							val = q.idx;
						else
							val = dat;
						n.flags[cpu_tail_pkg::FLAG_N] = val[7];
						n.flags[cpu_tail_pkg::FLAG_Z] = (val == 8'h00);
					end
					cpu_tail_pkg::op_xfer_index_to_acc: n.acc = q.idx;
					cpu_tail_pkg::op_wait, cpu_tail_pkg::op_stop: begin
						n.flags[cpu_tail_pkg::FLAG_I] = 1'b0;
						n.st = cpu_tail_pkg::st_halt;
						n.halted = 1'b1;
						next_fetch = 1'b0;
						if (dif.op == cpu_tail_pkg::op_stop) begin
							n.stop = 1'b1;
							n.irq_en = 1'b1;
						end
					end
					cpu_tail_pkg::op_jump: target = ea;
					cpu_tail_pkg::op_branch: begin
						if (branch_cond(dif.opcode[3:0], q.flags, q.sync2))
							target = rel_target(q.pc, rel);
					end
					cpu_tail_pkg::op_branch_bit: begin
						bitv = dat[dif.opcode[3:1]];
						n.flags[cpu_tail_pkg::FLAG_C] = bitv;
						if (bitv ^ dif.opcode[0])
							target = rel_target(q.pc, rel);
					end
					cpu_tail_pkg::op_multiply: begin
						prod = 16'(q.idx) * 16'(q.acc);
						n.idx = prod[15:8];
						n.acc = prod[7:0];
						n.flags[cpu_tail_pkg::FLAG_H] = 1'b0;
						n.flags[cpu_tail_pkg::FLAG_C] = 1'b0;
					end
					default: n.illegal = 1'b1;
				endcase
				if (next_fetch) begin
					n.maddr = target;
					n.mrd = 1'b1;
					n.pc = target + 16'h0001;
					n.st = cpu_tail_pkg::st_dec;
					n.cnt = 4'h0;
				end
			end
		end
	end

	// Pin idles high after reset so no false wake
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			q <= '0;
			q.st <= cpu_tail_pkg::st_fetch;
			q.flags <= cpu_tail_pkg::FLAGS_RST;
			q.acc <= cpu_tail_pkg::ACC_RST;
			q.idx <= cpu_tail_pkg::INDEX_RST;
			q.pc <= cpu_tail_pkg::PC_RST;
			q.sync1 <= 1'b1;
			q.sync2 <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign reg_rdata_out = q.rdata;
	assign mem_addr_out = q.maddr;
	assign mem_rd_out = q.mrd;
	assign halted_out = q.halted;
	assign osc_stop_out = q.stop;
	assign ext_irq_en_out = q.irq_en;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in || !q.run);

	sequence s_dec(logic [7:0] code);
		q.st == cpu_tail_pkg::st_dec && mem_rdata_in == code;
	endsequence
	sequence s_two_bytes(logic [7:0] code);
		s_dec(code) ##1 q.st == cpu_tail_pkg::st_op1 ##1 q.st == cpu_tail_pkg::st_op2;
	endsequence

	a_test_keeps_hic: assert property (ready && last && dif.op == cpu_tail_pkg::op_test_zero_neg
		|=> q.flags[4:3] == $past(q.flags[4:3]) && q.flags[0] == $past(q.flags[0]))
		else $error("test changed H, I or C");
	a_test_dir_len: assert property (s_dec(cpu_tail_pkg::OPC_TEST_DIR)
		|=> (q.st != cpu_tail_pkg::st_dec)[*3] ##1 q.st == cpu_tail_pkg::st_dec)
		else $error("direct test not four cycles");
	a_xfer_copy: assert property (s_dec(cpu_tail_pkg::OPC_XFER)
		|-> ##2 q.st == cpu_tail_pkg::st_dec && q.acc == $past(q.idx, 2) && $stable(q.flags))
		else $error("index to accumulator transfer wrong");
	a_wait_halts: assert property (s_dec(cpu_tail_pkg::OPC_WAIT)
		|-> ##2 q.halted && !q.stop && !q.flags[cpu_tail_pkg::FLAG_I])
		else $error("wait did not halt with mask clear");
	a_stop_pin_en: assert property (s_dec(cpu_tail_pkg::OPC_STOP)
		|-> ##2 q.halted && osc_stop_out && ext_irq_en_out && !q.flags[cpu_tail_pkg::FLAG_I])
		else $error("stop effects missing");
	a_ext_address: assert property (s_two_bytes(cpu_tail_pkg::OPC_JMP_EXT)
		|=> q.st == cpu_tail_pkg::st_dec && mem_addr_out == {$past(mem_rdata_in, 2), $past(mem_rdata_in)})
		else $error("extended address order wrong");
	a_ix2_sum: assert property (s_two_bytes(cpu_tail_pkg::OPC_JMP_IX2)
		|=> q.ea == {$past(mem_rdata_in, 2), $past(mem_rdata_in)} + {8'h00, $past(q.idx)})
		else $error("word offset address wrong");
	a_ix1_sum: assert property (s_dec(cpu_tail_pkg::OPC_TEST_IX1) ##1 q.st == cpu_tail_pkg::st_op1
		|=> mem_rd_out && mem_addr_out == {8'h00, $past(q.idx)} + {8'h00, $past(mem_rdata_in)})
		else $error("byte offset address wrong");
	a_ix_addr: assert property (s_dec(cpu_tail_pkg::OPC_TEST_IX)
		|=> q.st == cpu_tail_pkg::st_data && mem_addr_out == {8'h00, $past(q.idx)})
		else $error("no offset address wrong");
	a_rel_target: assert property (s_dec(8'h20) ##1 q.st == cpu_tail_pkg::st_op1
		|-> ##2 mem_addr_out == rel_target($past(q.pc, 2), $past(mem_rdata_in, 2)))
		else $error("always branch target wrong");
	a_illegal_flag: assert property (q.st == cpu_tail_pkg::st_dec && dif.op == cpu_tail_pkg::op_illegal
		|-> ##2 q.illegal)
		else $error("illegal opcode not flagged");

endmodule

// ==== cpu_tail_pkg.sv ====
package cpu_tail_pkg;

	// Register port offsets
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_ACC    = 4'h2;
	localparam logic [3:0] REG_INDEX  = 4'h3;
	localparam logic [3:0] REG_FLAGS  = 4'h4;
	localparam logic [3:0] REG_PC_LO  = 4'h5;
	localparam logic [3:0] REG_PC_HI  = 4'h6;

	// Field positions
	localparam int CTRL_RUN     = 0;
	localparam int STAT_HALT    = 0;
	localparam int STAT_STOP    = 1;
	localparam int STAT_ILLEGAL = 2;
	localparam int STAT_IRQ_EN  = 3;
	localparam int FLAG_C       = 0;
	localparam int FLAG_Z       = 1;
	localparam int FLAG_N       = 2;
	localparam int FLAG_I       = 3;
	localparam int FLAG_H       = 4;

	// Reset values; interrupt mask comes up set
	localparam logic [4:0]  FLAGS_RST = 5'h08;
	localparam logic [7:0]  ACC_RST   = 8'h00;
	localparam logic [7:0]  INDEX_RST = 8'h00;
	localparam logic [15:0] PC_RST    = 16'h0000;

	// Opcodes handled here
	localparam logic [7:0] OPC_TEST_DIR   = 8'h3D;
	localparam logic [7:0] OPC_TEST_ACC   = 8'h4D;
	localparam logic [7:0] OPC_TEST_INDEX = 8'h5D;
	localparam logic [7:0] OPC_TEST_IX1   = 8'h6D;
	localparam logic [7:0] OPC_TEST_IX    = 8'h7D;
	localparam logic [7:0] OPC_XFER       = 8'h9F;
	localparam logic [7:0] OPC_WAIT       = 8'h8F;
	localparam logic [7:0] OPC_STOP       = 8'h8E;
	localparam logic [7:0] OPC_MULTIPLY   = 8'h42;
	localparam logic [7:0] OPC_JMP_DIR    = 8'hBC;
	localparam logic [7:0] OPC_JMP_EXT    = 8'hCC;
	localparam logic [7:0] OPC_JMP_IX2    = 8'hDC;
	localparam logic [7:0] OPC_JMP_IX1    = 8'hEC;
	localparam logic [7:0] OPC_JMP_IX     = 8'hFC;
	localparam logic [3:0] NIB_BIT_BRANCH = 4'h0;
	localparam logic [3:0] NIB_BRANCH     = 4'h2;

	// Cycle counts
	localparam logic [3:0] CYC_TEST_DIR   = 4'h4;
	localparam logic [3:0] CYC_TEST_INH   = 4'h3;
	localparam logic [3:0] CYC_TEST_IX1   = 4'h5;
	localparam logic [3:0] CYC_TEST_IX    = 4'h4;
	localparam logic [3:0] CYC_XFER       = 4'h2;
	localparam logic [3:0] CYC_HALT       = 4'h2;
	localparam logic [3:0] CYC_MULTIPLY   = 4'hB;
	localparam logic [3:0] CYC_BIT_BRANCH = 4'h5;
	localparam logic [3:0] CYC_BRANCH     = 4'h3;
	localparam logic [3:0] CYC_JMP_DIR    = 4'h2;
	localparam logic [3:0] CYC_JMP_EXT    = 4'h3;
	localparam logic [3:0] CYC_JMP_IX2    = 4'h4;
	localparam logic [3:0] CYC_JMP_IX1    = 4'h3;
	localparam logic [3:0] CYC_JMP_IX     = 4'h2;
	localparam logic [3:0] CYC_ILLEGAL    = 4'h2;

	typedef enum logic [2:0] {
		inherent_mode, direct_mode, extended_mode, indexed_word_offset,
		indexed_byte_offset, indexed_no_offset, relative_mode, bit_rel_mode
	} mode_e;

	typedef enum logic [3:0] {
		op_test_zero_neg, op_xfer_index_to_acc, op_wait, op_stop, op_jump,
		op_branch, op_branch_bit, op_multiply, op_illegal
	} op_e;

	typedef enum logic [2:0] {
		st_fetch = 3'b000,
		st_dec   = 3'b001,
		st_op1   = 3'b011,
		st_op2   = 3'b010,
		st_data  = 3'b110,
		st_exec  = 3'b111,
		st_halt  = 3'b101
	} state_e;

endpackage

// ==== dec_if.sv ====
`timescale 1ns/1ps
interface dec_if;
	logic [7:0]            opcode;
	cpu_tail_pkg::op_e     op;
	cpu_tail_pkg::mode_e   mode;
	logic [3:0]            cycles;
	modport dec  (input opcode, output op, output mode, output cycles);
	modport core (output opcode, input op, input mode, input cycles);
endinterface

// ==== mem_model.sv ====
`timescale 1ns/1ps
// Zero-latency program and data store, read combinationally with no clock of its own
module mem_model (
	input  wire logic [15:0] addr_in,
	input  wire logic        rd_in,
	output logic      [7:0]  rdata_out
);
	logic [7:0] mem [0:65535];
	// Off-strobe the bus shows inverted data so a stale byte never looks valid
	assign rdata_out = rd_in ? mem[addr_in] : ~mem[addr_in];
	// Unused space holds a filler opcode that the core treats as illegal
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h9D;
		end
	end
endmodule

// ==== opcode_decoder.sv ====
`timescale 1ns/1ps
module opcode_decoder (
	dec_if.dec dif
);

	// High nibble picks class and mode, low nibble the operation
	always_comb begin
		dif.op = cpu_tail_pkg::op_illegal;
		dif.mode = cpu_tail_pkg::inherent_mode;
		dif.cycles = cpu_tail_pkg::CYC_ILLEGAL;
		if (dif.opcode[7:4] == cpu_tail_pkg::NIB_BIT_BRANCH) begin
			dif.op = cpu_tail_pkg::op_branch_bit;
			dif.mode = cpu_tail_pkg::bit_rel_mode;
			dif.cycles = cpu_tail_pkg::CYC_BIT_BRANCH;
		end else if (dif.opcode[7:4] == cpu_tail_pkg::NIB_BRANCH) begin
			dif.op = cpu_tail_pkg::op_branch;
			dif.mode = cpu_tail_pkg::relative_mode;
			dif.cycles = cpu_tail_pkg::CYC_BRANCH;
		end else begin
			case (dif.opcode)
				cpu_tail_pkg::OPC_TEST_DIR: begin
					dif.op = cpu_tail_pkg::op_test_zero_neg;
					dif.mode = cpu_tail_pkg::direct_mode;
					dif.cycles = cpu_tail_pkg::CYC_TEST_DIR;
				end
				cpu_tail_pkg::OPC_TEST_ACC, cpu_tail_pkg::OPC_TEST_INDEX: begin
					dif.op = cpu_tail_pkg::op_test_zero_neg;
					dif.cycles = cpu_tail_pkg::CYC_TEST_INH;
				end
				cpu_tail_pkg::OPC_TEST_IX1: begin
					dif.op = cpu_tail_pkg::op_test_zero_neg;
					dif.mode = cpu_tail_pkg::indexed_byte_offset;
					dif.cycles = cpu_tail_pkg::CYC_TEST_IX1;
				end
				cpu_tail_pkg::OPC_TEST_IX: begin
					dif.op = cpu_tail_pkg::op_test_zero_neg;
					dif.mode = cpu_tail_pkg::indexed_no_offset;
					dif.cycles = cpu_tail_pkg::CYC_TEST_IX;
				end
				cpu_tail_pkg::OPC_XFER: begin
					dif.op = cpu_tail_pkg::op_xfer_index_to_acc;
					dif.cycles = cpu_tail_pkg::CYC_XFER;
				end
				cpu_tail_pkg::OPC_WAIT: begin
					dif.op = cpu_tail_pkg::op_wait;
					dif.cycles = cpu_tail_pkg::CYC_HALT;
				end
				cpu_tail_pkg::OPC_STOP: begin
					dif.op = cpu_tail_pkg::op_stop;
					dif.cycles = cpu_tail_pkg::CYC_HALT;
				end
				cpu_tail_pkg::OPC_MULTIPLY: begin
					dif.op = cpu_tail_pkg::op_multiply;
					dif.cycles = cpu_tail_pkg::CYC_MULTIPLY;
				end
				cpu_tail_pkg::OPC_JMP_DIR: begin
					dif.op = cpu_tail_pkg::op_jump;
					dif.mode = cpu_tail_pkg::direct_mode;
					dif.cycles = cpu_tail_pkg::CYC_JMP_DIR;
				end
				cpu_tail_pkg::OPC_JMP_EXT: begin
					dif.op = cpu_tail_pkg::op_jump;
					dif.mode = cpu_tail_pkg::extended_mode;
					dif.cycles = cpu_tail_pkg::CYC_JMP_EXT;
				end
				cpu_tail_pkg::OPC_JMP_IX2: begin
					dif.op = cpu_tail_pkg::op_jump;
					dif.mode = cpu_tail_pkg::indexed_word_offset;
					dif.cycles = cpu_tail_pkg::CYC_JMP_IX2;
				end
				cpu_tail_pkg::OPC_JMP_IX1: begin
					dif.op = cpu_tail_pkg::op_jump;
					dif.mode = cpu_tail_pkg::indexed_byte_offset;
					dif.cycles = cpu_tail_pkg::CYC_JMP_IX1;
				end
				cpu_tail_pkg::OPC_JMP_IX: begin
					dif.op = cpu_tail_pkg::op_jump;
					dif.mode = cpu_tail_pkg::indexed_no_offset;
					dif.cycles = cpu_tail_pkg::CYC_JMP_IX;
				end
				default: begin
				end
			endcase
		end
	end

endmodule

// ==== tb_cpu_opcode_decode_tail.sv ====
`timescale 1ns/1ps
module tb_cpu_opcode_decode_tail;
	logic        sys_clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [3:0]  reg_addr_in = 4'h0;
	logic [7:0]  reg_wdata_in = 8'h00;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [7:0]  reg_rdata_out;
	logic [15:0] mem_addr_out;
	logic        mem_rd_out;
	logic [7:0]  mem_rdata_in;
	logic        ext_irq_n_in = 1'b1;
	logic        int_req_in = 1'b0;
	logic        halted_out;
	logic        osc_stop_out;
	logic        ext_irq_en_out;
	int          num_errors = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          rd_cyc [int];
	logic [7:0]  seed = 8'h5E;

	cpu_opcode_decode_tail cpu_opcode_decode_tail_inst (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
		.mem_rdata_in(mem_rdata_in), .ext_irq_n_in(ext_irq_n_in), .int_req_in(int_req_in),
		.halted_out(halted_out), .osc_stop_out(osc_stop_out), .ext_irq_en_out(ext_irq_en_out)
	);
	mem_model mem_model_inst (
		.addr_in(mem_addr_out), .rd_in(mem_rd_out), .rdata_out(mem_rdata_in)
	);

	// 200 MHz clock
	always #2.5 sys_clk_in = ~sys_clk_in;

	// First read cycle of each address, for cycle counts and operand forming
	always @(posedge sys_clk_in) begin
		cyc = cyc + 1;
		if (mem_rd_out === 1'b1 && !rd_cyc.exists(int'(mem_addr_out))) begin
			rd_cyc[int'(mem_addr_out)] = cyc;
		end
	end

	// Eight-bit LFSR, one step per call
	function automatic logic [7:0] rnd();
		seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
		return seed;
	endfunction

	task automatic end_sim;
		$display("errors %0d, checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe edge
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		chk({8'h00, reg_rdata_out}, {8'h00, exp}, what);
	endtask

	// Bounded wait for the halt flag to reach a level
	task automatic wait_halt(input logic lvl, input int n);
		for (int i = 0; i < n && halted_out !== lvl; i++) begin
			@(posedge sys_clk_in);
			#1;
		end
		if (halted_out !== lvl) begin
			num_errors++;
			$display("[FAIL] %0t halt wait timed out", $time);
			end_sim;
		end
		// Realign to a rising edge so the next stimulus lands on it
		@(posedge sys_clk_in);
	endtask

	// Main sequence: three runs of one program with fresh data each time
	initial begin
		logic [7:0]  m50, mx1, mx, a0, x;
		logic [15:0] base, off, xx;
		logic [7:0]  prog [18];
		int          ca [12], cn [12], cy [12];
		for (int it = 0; it < 3; it++) begin
			@(posedge sys_clk_in);
			rst_in <= 1'b1;
			repeat (20) @(posedge sys_clk_in);
			rst_in <= 1'b0;
			rd_cyc.delete();
			rchk(cpu_tail_pkg::REG_FLAGS, 8'h08, "reset flags");
			rchk(cpu_tail_pkg::REG_ACC, 8'h00, "reset acc");
			rchk(cpu_tail_pkg::REG_STATUS, 8'h00, "reset status");
			rchk(4'hF, 8'h00, "unmapped read");
			m50 = rnd();
			mx1 = rnd();
			mx = rnd();
			a0 = rnd();
			x = rnd();
			if (it == 0) begin
				mx = 8'h00;
				a0 = 8'h00;
			end
			x = 8'h80 | (x & 8'h3F);
			off = 16'h0030 - {8'h00, x};
			prog = '{8'h3D, 8'h50, 8'h4D, 8'h5D, 8'h6D, 8'h05, 8'h7D, 8'h9F, 8'hCC,
				8'h00, 8'h1C, 8'h9D, 8'h20, 8'h01, 8'h9D, 8'hDC, off[15:8], off[7:0]};
			foreach (prog[i]) mem_model_inst.mem[16'h0010 + i] = prog[i];
			mem_model_inst.mem[16'h0030] = 8'h00;
			mem_model_inst.mem[16'h0031] = 8'h50;
			mem_model_inst.mem[16'h0032] = 8'h08;
			for (int i = 0; i < 5; i++) begin
				mem_model_inst.mem[16'h0033 + i] = (i == 0 || i == 4) ? 8'h8F : 8'h8E;
				mem_model_inst.mem[16'h003B + i] = (i == 0 || i == 4) ? 8'h8F : 8'h8E;
			end
			foreach (ca[i]) ca[i] = 0;
			base = m50[0] ? 16'h003B : 16'h0033;
			mem_model_inst.mem[base + 16'h2] = 8'h42;
			mem_model_inst.mem[base + 16'h3] = 8'h9D;
			mem_model_inst.mem[16'h0050] = m50;
			mem_model_inst.mem[{8'h00, x} + 16'h5] = mx1;
			mem_model_inst.mem[{8'h00, x}] = mx;
			wr(cpu_tail_pkg::REG_ACC, a0);
			wr(cpu_tail_pkg::REG_INDEX, x);
			wr(cpu_tail_pkg::REG_FLAGS, 8'h19);
			wr(cpu_tail_pkg::REG_PC_LO, 8'h10);
			wr(cpu_tail_pkg::REG_PC_HI, 8'h00);
			wr(cpu_tail_pkg::REG_CTRL, 8'h01);
			wait_halt(1'b1, 200);
			rchk(cpu_tail_pkg::REG_FLAGS, {3'h0, 2'b10, mx[7], mx == 8'h00, m50[0]}, "flags");
			rchk(cpu_tail_pkg::REG_ACC, x, "xfer");
			int_req_in <= 1'b1;
			wait_halt(1'b0, 10);
			int_req_in <= 1'b0;
			wait_halt(1'b1, 20);
			chk({15'h0, osc_stop_out & ext_irq_en_out}, 16'h0001, "stop outs");
			int_req_in <= 1'b1;
			repeat (10) @(posedge sys_clk_in);
			chk({15'h0, halted_out}, 16'h0001, "stop woke on request");
			int_req_in <= 1'b0;
			ext_irq_n_in <= 1'b0;
			wait_halt(1'b0, 10);
			chk({15'h0, osc_stop_out}, 16'h0000, "osc after wake");
			ext_irq_n_in <= 1'b1;
			wait_halt(1'b1, 40);
			xx = {8'h00, x} * {8'h00, x};
			rchk(cpu_tail_pkg::REG_ACC, xx[7:0], "product low");
			rchk(cpu_tail_pkg::REG_INDEX, xx[15:8], "product high");
			rchk(cpu_tail_pkg::REG_FLAGS, {3'h0, 2'b00, mx[7], mx == 8'h00, 1'b0}, "mul flags");
			rchk(cpu_tail_pkg::REG_STATUS, 8'h0D, "status");
			rchk(cpu_tail_pkg::REG_PC_LO, base[7:0] + 8'h05, "pc");
			ca = '{'h10, 'h12, 'h13, 'h14, 'h16, 'h17, 'h18, 'h1C, 'h1F, 'h30, base + 2, base + 3};
			cn = '{'h12, 'h13, 'h14, 'h16, 'h17, 'h18, 'h1C, 'h1F, 'h30, base, base + 3, base + 4};
			cy = '{4, 3, 3, 5, 4, 2, 3, 3, 4, 5, 11, 2};
			foreach (ca[k]) begin
				chk(16'(rd_cyc[cn[k]] - rd_cyc[ca[k]]), 16'(cy[k]), "cycles");
			end
			chk(16'(rd_cyc.exists(16'h0050)), 16'h0001, "direct read");
			chk(16'(rd_cyc.exists({8'h00, x} + 16'h5)), 16'h0001, "byte offset");
			chk(16'(rd_cyc.exists({8'h00, x})), 16'h0001, "no offset");
			chk(16'(rd_cyc.exists(16'h001C)), 16'h0001, "extended target");
			chk(16'(rd_cyc.exists(16'h001F)), 16'h0001, "branch target");
			chk(16'(rd_cyc.exists(16'h0030)), 16'h0001, "word offset");
		end
		end_sim;
	end
endmodule
